/* File: logic/lane_map_pkg.sv */
// shared constants and carrier types for the lane sample mapper
package lane_map_pkg;

  // ------------------------------------------------------------
  // geometry
  // ------------------------------------------------------------
  localparam int NUM_LANES = 8;
  localparam int NUM_CH = 4;
  localparam int SMP_PER_CH = 10;
  localparam int SMP_BITS = 12;
  localparam int LANE_BITS = 64;
  localparam int MODE_BITS = 4;
  localparam int MODE_COUNT = 11;
  localparam int TAIL_BITS = 4;

  // ------------------------------------------------------------
  // values after reset
  // ------------------------------------------------------------
  localparam logic [3:0] MODE_RST = 4'h0;
  localparam logic [7:0] LANE_EN_RST = 8'h00;
  localparam logic [3:0] OCTETS_RST = 4'h0;

  // ------------------------------------------------------------
  // per mode: lanes in use and octets per lane frame, index = mode
  // ------------------------------------------------------------
  localparam logic [10:0][3:0] LANES_PER_MODE = {
    4'h8, 4'h8, 4'h4, 4'h4, 4'h6, 4'h2, 4'h3, 4'h4, 4'h4, 4'h6, 4'h8};
  localparam logic [10:0][3:0] OCTETS_PER_MODE = {
    4'h5, 4'h1, 4'h3, 4'h1, 4'h2, 4'h2, 4'h2, 4'h5, 4'h1, 4'h2, 4'h8};

  // ------------------------------------------------------------
  // carriers
  // ------------------------------------------------------------
  typedef logic [SMP_BITS-1:0] smp_t;
  typedef smp_t [SMP_PER_CH-1:0] ch_smp_t;
  // channel 0 = A .. 3 = D, sample n at index n, right aligned
  typedef ch_smp_t [NUM_CH-1:0] smp_set_t;
  // octet 0 of each lane frame sits in bits [63:56]
  typedef logic [NUM_LANES-1:0][LANE_BITS-1:0] lane_frame_t;

  typedef struct packed {
    logic [MODE_BITS-1:0] mode;
    logic mode_ok;
    logic [NUM_LANES-1:0] lane_en;
    logic [3:0] octets;
  } map_cfg_t;

endpackage : lane_map_pkg

/* File: logic/frame_skid_buffer.sv */
// two-entry skid buffer, all outputs registered
`timescale 1ns/100ps
module frame_skid_buffer #(
  parameter int W = 512
) (
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_srst,
  // fill side
  input wire logic i_valid,
  input wire logic [W-1:0] i_data,
  output logic o_ready,
  // drain side
  output logic o_valid,
  output logic [W-1:0] o_data,
  input wire logic i_ready
);

  typedef struct packed {
    logic out_v;
    logic [W-1:0] out_d;
    logic skid_v;
    logic [W-1:0] skid_d;
    logic rdy;
  } buf_st_t;

  buf_st_t st_q;
  buf_st_t st_d;

  always_comb begin
    st_d = st_q;
    if (!st_q.out_v || i_ready) begin
      if (st_q.skid_v) begin
        st_d.out_v = 1'b1;
        st_d.out_d = st_q.skid_d;
        st_d.skid_v = 1'b0;
      end else begin
        st_d.out_v = i_valid && st_q.rdy;
        st_d.out_d = i_data;
      end
    end else if (i_valid && st_q.rdy) begin
      // receiver stalled: park the word instead of losing it
      st_d.skid_v = 1'b1;
      st_d.skid_d = i_data;
    end
    st_d.rdy = !st_d.skid_v;
  end

  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      st_q <= '0;
      st_q.rdy <= 1'b1;
    end else begin
      st_q <= st_d;
    end
  end

  assign o_ready = st_q.rdy;
  assign o_valid = st_q.out_v;
  assign o_data = st_q.out_d;

endmodule : frame_skid_buffer

/* File: logic/adc_lane_sample_mapper.sv */
// transport-layer sample mapper: channel samples to per-lane octet frames
// ------------------------------------------------------------
// ------------------------------------------------------------
`timescale 1ns/100ps
module adc_lane_sample_mapper (
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_srst,
  // configuration
  input wire logic [lane_map_pkg::MODE_BITS-1:0] i_lane_map_mode,
  input wire logic i_link_run,
  // sample side
  input wire logic i_smp_valid,
  input wire lane_map_pkg::smp_set_t i_smp,
  output logic o_smp_ready,
  // lane side
  output logic o_frame_valid,
  output lane_map_pkg::lane_frame_t o_frame,
  input wire logic i_frame_ready,
  // lane status
  output logic [lane_map_pkg::NUM_LANES-1:0] o_lane_en,
  output logic [3:0] o_octets,
  output logic o_mode_err
);
  import lane_map_pkg::*;

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic logic mode_valid(input logic [MODE_BITS-1:0] m);
    mode_valid = (m < MODE_BITS'(MODE_COUNT));
  endfunction : mode_valid

  function automatic logic [NUM_LANES-1:0] lane_mask(input logic [3:0] n);
    logic [NUM_LANES:0] one_hot;
    one_hot = (NUM_LANES+1)'(1) << n;
    lane_mask = NUM_LANES'(one_hot - (NUM_LANES+1)'(1));
  endfunction : lane_mask

  // ------------------------------------------------------------
  // frame packing; every bit not written stays zero, so tails are 0
  // ------------------------------------------------------------
  function automatic lane_frame_t pack(input logic [MODE_BITS-1:0] m,
                                       input smp_set_t s);
    lane_frame_t f;
    logic [95:0] cat96;
    logic [47:0] cat48;
    int ch;
    int par;
    f = '0;
    cat96 = {s[0][0], s[0][1], s[1][0], s[1][1],
             s[2][0], s[2][1], s[3][0], s[3][1]};
    cat48 = {s[0][0], s[1][0], s[2][0], s[3][0]};
    // concatenations below put the first sample in the high bits
    for (int l = 0; l < NUM_LANES; l++) begin
      ch = l / 2;
      par = l % 2;
      case (m)
        4'h0: begin
          // five even or odd samples, then a zero tail nibble
          f[l] = {s[ch][par], s[ch][par+2], s[ch][par+4], s[ch][par+6],
                  s[ch][par+8], TAIL_BITS'(0)};
        end
        4'h1, 4'h6: begin
          // 16-bit slices of the 96-bit stream
          if (l < 6) begin
            f[l][63:48] = cat96[95-16*l -: 16];
          end
        end
        4'h2, 4'h7: begin
          if (l < NUM_CH) begin
            f[l][63:56] = s[l][0][7:0];
          end
        end
        4'h3: begin
          if (l < NUM_CH) begin
            f[l][63:24] = {s[l][0][9:0], s[l][1][9:0],
                           s[l][2][9:0], s[l][3][9:0]};
          end
        end
        4'h4: begin
          if (l < 3) begin
            f[l][63:48] = cat48[47-16*l -: 16];
          end
        end
        4'h5: begin
          if (l < 2) begin
            f[l][63:48] = {s[2*l][0][7:0], s[2*l+1][0][7:0]};
          end
        end
        4'h8: begin
          if (l < NUM_CH) begin
            f[l][63:40] = {s[l][0], s[l][1]};
          end
        end
        4'h9: begin
          f[l][63:56] = s[ch][par][7:0];
        end
        4'ha: begin
          f[l][63:24] = {s[ch][par][9:0], s[ch][par+2][9:0],
                         s[ch][par+4][9:0], s[ch][par+6][9:0]};
        end
        default: begin
          f[l] = '0;
        end
      endcase
    end
    pack = f;
  endfunction : pack

  // ------------------------------------------------------------
  // configuration state
  // ------------------------------------------------------------
  map_cfg_t st_q;
  map_cfg_t st_d;

  always_comb begin
    st_d = st_q;
    // a mode change mid-link would slip frame boundaries
    if (!i_link_run) begin
      st_d.mode = i_lane_map_mode;
      st_d.mode_ok = mode_valid(i_lane_map_mode);
      if (st_d.mode_ok) begin
        // lowest lanes only, the rest held off
        st_d.lane_en = lane_mask(LANES_PER_MODE[i_lane_map_mode]);
        st_d.octets = OCTETS_PER_MODE[i_lane_map_mode];
      end else begin
        st_d.lane_en = LANE_EN_RST;
        st_d.octets = OCTETS_RST;
      end
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      st_q.mode <= MODE_RST;
      st_q.mode_ok <= 1'b1;
      st_q.lane_en <= LANE_EN_RST;
      st_q.octets <= OCTETS_RST;
    end else begin
      st_q <= st_d;
    end
  end

  // ------------------------------------------------------------
  // output buffer
  // ------------------------------------------------------------
  lane_frame_t packed_frame;

  always_comb begin
    packed_frame = pack(st_q.mode, i_smp);
  end

  frame_skid_buffer #(
    .W(NUM_LANES*LANE_BITS)
  ) u_buf (
    .i_mclk(i_mclk),
    .i_srst(i_srst),
    .i_valid(i_smp_valid),
    .i_data(packed_frame),
    .o_ready(o_smp_ready),
    .o_valid(o_frame_valid),
    .o_data(o_frame),
    .i_ready(i_frame_ready)
  );

  assign o_lane_en = st_q.lane_en;
  assign o_octets = st_q.octets;
  assign o_mode_err = !st_q.mode_ok;

endmodule : adc_lane_sample_mapper

/* File: sim/lane_map_asserts.sv */
// port-level checks for the lane sample mapper
`timescale 1ns/100ps
module lane_map_asserts (
  // watched ports
  input wire logic i_mclk,
  input wire logic i_srst,
  input wire logic [3:0] i_lane_map_mode,
  input wire logic i_link_run,
  input wire logic i_smp_valid,
  input wire logic o_smp_ready,
  input wire logic o_frame_valid,
  input wire lane_map_pkg::lane_frame_t o_frame,
  input wire logic i_frame_ready,
  input wire logic [7:0] o_lane_en,
  input wire logic [3:0] o_octets,
  input wire logic o_mode_err
);
  default clocking @(posedge i_mclk); endclocking
  default disable iff (i_srst);
  property p_rst;
    $fell(i_srst) |-> o_smp_ready && !o_frame_valid && o_lane_en == 8'h00;
  endproperty
  a_rst: assert property (p_rst) else $error("bad state after reset");
  property p_hold;
    o_frame_valid && !i_frame_ready |=> o_frame_valid && $stable(o_frame);
  endproperty
  a_hold: assert property (p_hold) else $error("frame lost under stall");
  property p_take; i_smp_valid && o_smp_ready |=> o_frame_valid; endproperty
  a_take: assert property (p_take) else $error("taken set gave no frame");
  property p_park; !o_smp_ready |-> o_frame_valid; endproperty
  a_park: assert property (p_park) else $error("refusing with empty output");
  property p_frz; i_link_run [*2] |=> $stable(o_lane_en) && $stable(o_octets); endproperty
  a_frz: assert property (p_frz) else $error("config moved while running");
  property p_bad;
    !i_link_run && i_lane_map_mode > 4'ha |=> o_mode_err && o_lane_en == 8'h00;
  endproperty
  a_bad: assert property (p_bad) else $error("invalid mode not flagged");
  property p_m0;
    !i_link_run && i_lane_map_mode == 4'h0 |=> o_lane_en == 8'hff && o_octets == 4'h8;
  endproperty
  a_m0: assert property (p_m0) else $error("mode 0 geometry wrong");
  property p_low; o_lane_en inside {8'h00, 8'h03, 8'h07, 8'h0f, 8'h3f, 8'hff}; endproperty
  a_low: assert property (p_low) else $error("lanes not lowest first");
endmodule : lane_map_asserts
bind adc_lane_sample_mapper lane_map_asserts u_chk (.i_mclk, .i_srst, .i_lane_map_mode,
  .i_link_run, .i_smp_valid, .o_smp_ready, .o_frame_valid, .o_frame, .i_frame_ready,
  .o_lane_en, .o_octets, .o_mode_err);

/* File: sim/frame_sink.sv */
// receiving link logic: takes lane frames, may stall
`timescale 1ns/100ps
module frame_sink (
  input wire logic i_mclk,
  input wire logic i_stall,
  input wire logic i_valid,
  input wire lane_map_pkg::lane_frame_t i_frame,
  output logic o_ready
);
  lane_map_pkg::lane_frame_t q[$];
  assign o_ready = !i_stall;
  // all eight lanes wired, lowest first
  always @(posedge i_mclk) if (i_valid && o_ready) q.push_back(i_frame);
endmodule : frame_sink

/* File: sim/testbench.sv */
// self-checking bench for the lane sample mapper
`timescale 1ns/100ps
module testbench;
  import lane_map_pkg::*;
  logic i_mclk = 0, i_srst = 1, i_link_run = 0, i_smp_valid = 0, stall = 0;
  logic [3:0] i_lane_map_mode = 4'h0;
  smp_set_t i_smp = '0;
  logic o_smp_ready, o_frame_valid, o_mode_err, i_frame_ready;
  lane_frame_t o_frame;
  logic [7:0] o_lane_en;
  logic [3:0] o_octets;
  int n_fail = 0, n_checks = 0, cyc = 0;
  int lanes[11] = '{8, 6, 4, 4, 3, 2, 6, 4, 4, 8, 8};
  int octs[11] = '{8, 2, 1, 5, 2, 2, 2, 1, 3, 1, 5};
  always #2 i_mclk = ~i_mclk;
  adc_lane_sample_mapper dut (.i_mclk, .i_srst, .i_lane_map_mode, .i_link_run, .i_smp_valid,
    .i_smp, .o_smp_ready, .o_frame_valid, .o_frame, .i_frame_ready, .o_lane_en, .o_octets,
    .o_mode_err);
  frame_sink sink (.i_mclk, .i_stall(stall), .i_valid(o_frame_valid), .i_frame(o_frame),
    .o_ready(i_frame_ready));
  task automatic end_sim;
    $display("checks %0d fails %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : end_sim
  always @(posedge i_mclk) begin
    cyc++;
    if (cyc == 3000) begin
      n_fail++;
      end_sim();
    end
  end
  task automatic chk(logic [511:0] got, logic [511:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  function automatic smp_set_t mk(int b);
    smp_set_t s;
    for (int c = 0; c < 4; c++)
      for (int n = 0; n < 10; n++)
        s[c][n] = 12'(b * 'h35 + 'h2d9 * c + 'h1b3 * n);
    return s;
  endfunction : mk
  // reference packing: first sample in the high bits, unused bits zero
  function automatic lane_frame_t expf(int m, smp_set_t s);
    lane_frame_t f;
    logic [127:0] st;
    int w, pr, two, cnt;
    f = '0;
    st = '0;
    w = (m inside {2, 5, 7, 9}) ? 8 : (m inside {3, 10}) ? 10 : 12;
    pr = m inside {0, 9, 10};
    two = m inside {1, 6};
    cnt = m == 0 ? 5 : (m inside {3, 10}) ? 4 : m == 8 ? 2 : 1;
    if (m inside {1, 4, 5, 6}) begin
      for (int k = 0; k < (two ? 8 : 4); k++)
        st |= 128'(s[two ? k / 2 : k][two ? k % 2 : 0] & ((1 << w) - 1)) << (128 - w * (k + 1));
      for (int l = 0; l < 8; l++) f[l][63:48] = st[127 - 16 * l -: 16];
    end else if (m < 11) begin
      for (int l = 0; l < (pr ? 8 : 4); l++)
        for (int k = 0; k < cnt; k++)
          f[l] |= 64'(s[pr ? l / 2 : l][pr ? l % 2 + 2 * k : k] & ((1 << w) - 1))
                  << (64 - w * (k + 1));
    end
    return f;
  endfunction : expf
  task automatic setmode(int m);
    i_link_run = 0;
    i_lane_map_mode = 4'(m);
    repeat (3) @(negedge i_mclk);
    i_link_run = 1;
  endtask : setmode
  task automatic send(smp_set_t s);
    i_smp_valid = 1;
    i_smp = s;
    while (o_smp_ready !== 1'b1) @(negedge i_mclk);
    @(negedge i_mclk);
  endtask : send
  task automatic got(lane_frame_t e);
    while (sink.q.size() == 0) @(negedge i_mclk);
    chk(sink.q.pop_front(), e);
  endtask : got
  task automatic t_modes;
    int md;
    for (int m = 0; m < 12; m++) begin
      md = (m == 11) ? 15 : m;
      setmode(md);
      chk(512'(o_lane_en), m > 10 ? 0 : 512'((1 << lanes[m]) - 1));
      chk(512'(o_octets), m > 10 ? 0 : 512'(octs[m]));
      chk(512'(o_mode_err), 512'(m > 10));
      send(mk(m));
      i_smp_valid = 0;
      got(expf(md, mk(m)));
    end
  endtask : t_modes
  task automatic t_freeze;
    setmode(3);
    i_lane_map_mode = 4'h5;
    repeat (3) @(negedge i_mclk);
    chk(512'({o_lane_en, o_octets}), 512'h0f5);
    send(mk(20));
    i_smp_valid = 0;
    got(expf(3, mk(20)));
  endtask : t_freeze
  // fill the two-entry buffer against a stalled sink, then drain
  task automatic t_stall;
    setmode(0);
    stall = 1;
    send(mk(30));
    send(mk(31));
    i_smp_valid = 0;
    repeat (4) @(negedge i_mclk);
    chk(512'(o_smp_ready), 0);
    stall = 0;
    got(expf(0, mk(30)));
    got(expf(0, mk(31)));
    send(mk(32));
    send(mk(33));
    i_smp_valid = 0;
    got(expf(0, mk(32)));
    got(expf(0, mk(33)));
    chk(512'(o_smp_ready), 1);
  endtask : t_stall
  initial begin
    repeat (4) @(negedge i_mclk);
    i_srst = 0;
    t_modes();
    t_freeze();
    t_stall();
    end_sim();
  end
endmodule : testbench
